// File: src/ucr_rx_top.sv
// ucr_rx_top: start-bit qualification, clock recovery and majority-vote data recovery
// assumes: sample_tick_i pulses one cycle at 16x baud (8x when double_speed_sel_i is high);
// assumes: frame length (data plus parity) is steady while a frame is in flight
`timescale 1ns/1ps

module ucr_rx_top (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        rxd_i,
  input  wire logic                        sample_tick_i,
  input  wire logic                        double_speed_sel_i,
  input  wire logic [3:0]                  char_len_i,
  output logic                             rx_valid_o,
  input  wire logic                        rx_ready_i,
  output logic [ucr_pkg::DATA_W-1:0]       rx_data_o,
  output logic                             frame_error_flag_o,
  output logic                             overrun_o,
  output logic                             busy_o
);

  // ****************************************
  // declarations
  // ****************************************
  ucr_pkg::ucr_state_t        state_ff;
  ucr_pkg::ucr_state_t        nxt_state;
  logic                       rxd_s;
  logic                       line_prev_ff;
  logic                       dbl_ff;
  logic [3:0]                 len_ff;
  logic [4:0]                 cnt_ff;
  logic [4:0]                 nxt_cnt;
  logic [1:0]                 vote_ff;
  logic [3:0]                 bit_ff;
  logic [ucr_pkg::DATA_W-1:0] shreg_ff;
  logic                       pend_ff;
  logic [ucr_pkg::WORD_W-1:0] word_ff;
  logic                       ovr_ff;
  logic [ucr_pkg::WORD_W-1:0] fifo_word;

  ucr_stream_if               frm_if ();

  // ****************************************
  // input synchroniser and output fifo
  // ****************************************
  ucr_sync2 u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (rxd_i),
    .sync_o  (rxd_s)
  );

  ucr_fifo #(
    .WIDTH (ucr_pkg::WORD_W),
    .DEPTH (ucr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_if       (frm_if),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (fifo_word)
  );

  // error bit stays with its own word until that word is read
  assign rx_data_o          = fifo_word[ucr_pkg::DATA_W-1:0];
  assign frame_error_flag_o = fifo_word[ucr_pkg::FE_POS];
  assign frm_if.valid       = pend_ff;
  assign frm_if.data        = word_ff;
  assign overrun_o          = ovr_ff;
  assign busy_o             = (state_ff != ucr_pkg::ST_IDLE);

  // ****************************************
  // mode and length decoding
  // ****************************************
  // mode latched per frame so a mid-frame change cannot skew the count
  wire       dbl_now   = (state_ff == ucr_pkg::ST_IDLE) ? double_speed_sel_i : dbl_ff;
  wire [4:0] spb       = dbl_now ? ucr_pkg::SPB_DBL : ucr_pkg::SPB_NORM;
  wire [4:0] s_first   = dbl_now ? ucr_pkg::SF_DBL : ucr_pkg::SF_NORM;
  wire [4:0] s_last    = s_first + ucr_pkg::VOTE_SPAN;
  // out-of-range lengths are clamped rather than trusted
  wire [3:0] len_clamp = (char_len_i < ucr_pkg::LEN_MIN) ? ucr_pkg::LEN_MIN :
                         (char_len_i > ucr_pkg::LEN_MAX) ? ucr_pkg::LEN_MAX : char_len_i;

  // ****************************************
  // sample counter and voting
  // ****************************************
  // tick spacing is the receiver's whole share of the rate budget, no slack here
  // counter walks states 1..spb, the state number is the sample number
  wire [4:0] samp_nxt = (cnt_ff == spb) ? ucr_pkg::SAMPLE_FIRST : cnt_ff + ucr_pkg::SAMPLE_FIRST;
  wire       in_win   = (samp_nxt >= s_first) && (samp_nxt <= s_last);
  wire       is_dec   = sample_tick_i && (state_ff != ucr_pkg::ST_IDLE) && (samp_nxt == s_last);
  wire       vote     = ucr_pkg::maj3(vote_ff[1], vote_ff[0], rxd_s);
  wire       fall     = sample_tick_i && (state_ff == ucr_pkg::ST_IDLE)
                        && line_prev_ff && !rxd_s;
  wire       last_bit = ((bit_ff + ucr_pkg::BIT_ONE) == len_ff);
  wire       stop_dec = is_dec && (state_ff == ucr_pkg::ST_STOP);
  wire [3:0] shamt    = ucr_pkg::LEN_MAX - len_ff;
  wire [ucr_pkg::DATA_W-1:0] data_al = shreg_ff >> shamt;

  // ****************************************
  // recovery state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ucr_pkg::ST_IDLE: begin
        if (fall) begin
          nxt_state = ucr_pkg::ST_START;
        end
      end
      ucr_pkg::ST_START: begin
        if (is_dec) begin
          // high majority is noise, otherwise timing is now locked to this edge
          nxt_state = vote ? ucr_pkg::ST_IDLE : ucr_pkg::ST_DATA;
        end
      end
      ucr_pkg::ST_DATA: begin
        if (is_dec && last_bit) begin
          nxt_state = ucr_pkg::ST_STOP;
        end
      end
      ucr_pkg::ST_STOP: begin
        // back to idle straight after the stop vote; later stop bits are never looked at
        if (is_dec) begin
          nxt_state = ucr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ucr_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (fall) begin
      nxt_cnt = ucr_pkg::SAMPLE_FIRST;
    end else if (sample_tick_i && (state_ff != ucr_pkg::ST_IDLE)) begin
      nxt_cnt = (nxt_state == ucr_pkg::ST_IDLE) ? ucr_pkg::SAMPLE_IDLE : samp_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= ucr_pkg::ST_IDLE;
      cnt_ff       <= ucr_pkg::SAMPLE_IDLE;
      line_prev_ff <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      line_prev_ff <= sample_tick_i ? rxd_s : line_prev_ff;
    end
  end

  // frame settings captured at the edge, re-done each frame
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dbl_ff <= 1'b0;
      len_ff <= ucr_pkg::LEN_MAX;
    end else if (fall) begin
      dbl_ff <= double_speed_sel_i;
      len_ff <= len_clamp;
    end
  end

  // ****************************************
  // centre samples, bit count, shift register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vote_ff <= 2'b11;
    end else if (sample_tick_i && in_win) begin
      vote_ff <= {vote_ff[0], rxd_s};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_ff   <= ucr_pkg::BIT_ZERO;
      shreg_ff <= '0;
    end else if (fall) begin
      bit_ff   <= ucr_pkg::BIT_ZERO;
    end else if (is_dec && (state_ff == ucr_pkg::ST_DATA)) begin
      bit_ff   <= bit_ff + ucr_pkg::BIT_ONE;
      shreg_ff <= {vote, shreg_ff[ucr_pkg::DATA_W-1:1]};
    end
  end

  // ****************************************
  // frame hand-off to the fifo
  // ****************************************
  // one holding word; a second frame finishing while it waits is dropped
  wire hold_busy = pend_ff && !frm_if.ready;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_ff <= 1'b0;
      word_ff <= '0;
      ovr_ff  <= 1'b0;
    end else begin
      ovr_ff <= stop_dec && hold_busy;
      if (stop_dec && !hold_busy) begin
        pend_ff <= 1'b1;
        word_ff <= {~vote, data_al};
      end else if (pend_ff && frm_if.ready) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // check helpers
  // ****************************************
  // kept apart from cnt_ff so the spacing checks do not lean on the counter they judge
  logic [4:0]                 gap_ff;
  logic [4:0]                 nxt_gap;
  logic [3:0]                 dec_n_ff;
  logic [3:0]                 nxt_dec_n;

  always_comb begin
    nxt_gap   = gap_ff;
    nxt_dec_n = dec_n_ff;
    if (fall) begin
      nxt_gap   = '0;
      nxt_dec_n = ucr_pkg::BIT_ZERO;
    end else if (is_dec) begin
      nxt_gap   = '0;
      nxt_dec_n = dec_n_ff + ucr_pkg::BIT_ONE;
    end else if (sample_tick_i && (state_ff != ucr_pkg::ST_IDLE)) begin
      nxt_gap   = gap_ff + ucr_pkg::SAMPLE_FIRST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gap_ff   <= '0;
      dec_n_ff <= ucr_pkg::BIT_ZERO;
    end else begin
      gap_ff   <= nxt_gap;
      dec_n_ff <= nxt_dec_n;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_sample_bound: assert property (cnt_ff <= spb)
    else $error("sample counter beyond samples per bit");

  a_start_reject: assert property (
    (state_ff == ucr_pkg::ST_START) && is_dec && vote |=> state_ff == ucr_pkg::ST_IDLE)
    else $error("noisy start bit not rejected");

  a_start_accept: assert property (
    (state_ff == ucr_pkg::ST_START) && is_dec && !vote |=>
      (state_ff == ucr_pkg::ST_DATA) && (bit_ff == ucr_pkg::BIT_ZERO))
    else $error("valid start bit not accepted");

  a_fall_qualify: assert property (
    fall |=> (state_ff == ucr_pkg::ST_START) && (cnt_ff == ucr_pkg::SAMPLE_FIRST))
    else $error("falling edge did not start qualification at sample one");

  a_stop_release: assert property (
    stop_dec |=> (state_ff == ucr_pkg::ST_IDLE) && (cnt_ff == ucr_pkg::SAMPLE_IDLE))
    else $error("receiver not idle right after stop vote");

  a_frame_error: assert property (
    stop_dec && !hold_busy |=> pend_ff && (word_ff[ucr_pkg::FE_POS] == !$past(vote)))
    else $error("frame error not matching stop vote");

  a_word_hold: assert property (
    pend_ff && !frm_if.ready |=> pend_ff && $stable(word_ff))
    else $error("pending frame word changed before acceptance");

  a_bit_range: assert property (
    (state_ff == ucr_pkg::ST_DATA) |-> (bit_ff < len_ff))
    else $error("bit count passed frame length");

  a_len_range: assert property (
    (len_ff >= ucr_pkg::LEN_MIN) && (len_ff <= ucr_pkg::LEN_MAX))
    else $error("frame length outside five to ten");

  a_mode_stable: assert property (
    (state_ff != ucr_pkg::ST_IDLE) && ($past(state_ff) != ucr_pkg::ST_IDLE) |-> $stable(dbl_ff))
    else $error("speed mode changed inside a frame");

  a_vote_point: assert property (
    is_dec |-> (samp_nxt == (dbl_ff ? ucr_pkg::SF_DBL : ucr_pkg::SF_NORM) + ucr_pkg::VOTE_SPAN))
    else $error("vote taken at wrong sample");

  a_sync_delay: assert property (
    $past(rst_n_i) && $past(rst_n_i, 2) |-> rxd_s == $past(rxd_i, 2))
    else $error("line not delayed by exactly two flops");

  a_idle_count: assert property (
    (state_ff == ucr_pkg::ST_IDLE) |-> (cnt_ff == ucr_pkg::SAMPLE_IDLE))
    else $error("sample count not zero while idle");

  a_mode_latch: assert property (
    fall |=> dbl_ff == $past(double_speed_sel_i))
    else $error("speed mode not taken at start edge");

  a_start_spacing: assert property (
    (state_ff == ucr_pkg::ST_START) && is_dec |-> (gap_ff == (spb >> 1)))
    else $error("start vote not at centre of start bit");

  a_bit_spacing: assert property (
    (state_ff != ucr_pkg::ST_START) && is_dec |-> (gap_ff == spb - ucr_pkg::SAMPLE_FIRST))
    else $error("bit votes not one bit period apart");

  a_frame_bits: assert property (
    stop_dec |-> (dec_n_ff == len_ff + ucr_pkg::BIT_ONE))
    else $error("stop vote after wrong number of bits");

  a_shift_in: assert property (
    is_dec && (state_ff == ucr_pkg::ST_DATA) |=> (shreg_ff[ucr_pkg::DATA_W-1] == $past(vote)))
    else $error("voted bit not shifted in");

  a_align_zero: assert property (
    stop_dec |-> ((data_al >> len_ff) == '0))
    else $error("bits above frame length not clear");

  a_drop_keep: assert property (
    stop_dec && hold_busy |=> ovr_ff && $stable(word_ff))
    else $error("dropped frame disturbed pending word");

  a_overrun_src: assert property (
    ovr_ff |-> $past(stop_dec) && $past(hold_busy))
    else $error("overrun without a blocked frame");

  a_head_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o) && $stable(frame_error_flag_o))
    else $error("head word changed before it was taken");

  c_frame_ok:   cover property (stop_dec && vote && !dbl_ff);
  c_frame_dbl:  cover property (stop_dec && dbl_ff);
  c_frame_err:  cover property (stop_dec && !vote);
  c_start_drop: cover property ((state_ff == ucr_pkg::ST_START) && is_dec && vote);
  c_overrun:    cover property (ovr_ff);

endmodule : ucr_rx_top

// File: src/ucr_pkg.sv
// ucr_pkg: constants, types and helpers for the uart receive clock/data recovery block
// assumes: one system clock, a baud sample tick at 16x (or 8x in double speed) from outside

package ucr_pkg;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int unsigned DATA_W     = 10;
  localparam int unsigned WORD_W     = 11;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FE_POS     = 10;

  // ****************************************
  // sampling figures
  // ****************************************
  localparam logic [4:0] SPB_NORM     = 5'h10;
  localparam logic [4:0] SPB_DBL      = 5'h08;
  localparam logic [4:0] SF_NORM      = 5'h08;
  localparam logic [4:0] SF_DBL       = 5'h04;
  localparam logic [4:0] VOTE_SPAN    = 5'h02;
  localparam logic [4:0] SAMPLE_FIRST = 5'h01;
  localparam logic [4:0] SAMPLE_IDLE  = 5'h00;

  localparam logic [3:0] LEN_MIN  = 4'h5;
  localparam logic [3:0] LEN_MAX  = 4'hA;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE  = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } ucr_state_t;

  // two of three wins
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

endpackage : ucr_pkg

// File: src/ucr_stream_if.sv
// ucr_stream_if: valid/ready word stream between the recovery core and its fifo
// assumes: both ends on the same clock
`timescale 1ns/1ps

interface ucr_stream_if;
  logic                       valid;
  logic                       ready;
  logic [ucr_pkg::WORD_W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ucr_stream_if

// File: src/ucr_sync2.sv
// ucr_sync2: two-flop synchroniser for the asynchronous serial line
// assumes: line idles high, so both flops reset high
`timescale 1ns/1ps

module ucr_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;
  logic sync_ff;

  // first flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : ucr_sync2

// File: src/ucr_fifo.sv
// ucr_fifo: flop-based word fifo with valid/ready on both sides
// assumes: single clock, depth a power of two
`timescale 1ns/1ps

module ucr_fifo #(
  parameter int unsigned WIDTH = ucr_pkg::WORD_W,
  parameter int unsigned DEPTH = ucr_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  ucr_stream_if.snk             in_if,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  wire              full  = (cnt_ff == (AW+1)'(DEPTH));
  wire              empty = (cnt_ff == '0);
  wire              push  = in_if.valid & ~full;
  wire              pop   = out_ready_i & ~empty;

  assign in_if.ready = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_ff[rd_ff];

  // each entry loads only when the write index points at it
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk_i) begin
      if (push && (wr_ff == AW'(i))) begin
        mem_ff[i] <= in_if.data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= push ? wr_ff + AW'(1) : wr_ff;
      rd_ff  <= pop ? rd_ff + AW'(1) : rd_ff;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ucr_fifo

// File: test/ucr_tx_model.sv
// ucr_tx_model: remote asynchronous transmitter on the serial line
// assumes: caller gives bit length in system clocks; line idles high
`timescale 1ns/1ps

module ucr_tx_model (
  input  wire logic clk_i,
  output logic      line_o
);
  // ****************************************
  // line driver
  // ****************************************
  initial line_o = 1'b1;

  // start, len bits lsb first, one stop of stop_clks, then idle high
  // caller keeps bclk inside the acceptance ratio
  task automatic send(input logic [9:0] d, input int len, input int bclk, input logic stp, input int stop_clks);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (bclk) @(posedge clk_i);
    for (int i = 0; i < len; i++) begin
      line_o <= d[i];
      repeat (bclk) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (stop_clks) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : send

  // short low spike, too short to pass the centre vote
  task automatic glitch(input int clks);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (clks) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : glitch
endmodule : ucr_tx_model

// File: test/uart_rx_clock_data_recovery_tb.sv
// uart_rx_clock_data_recovery_tb: random and corner frames through the receive front end
// assumes: tick every 4 clocks, so 64 clocks a bit normal, 32 in double speed
`timescale 1ns/1ps

module uart_rx_clock_data_recovery_tb;
  // ****************************************
  // signals
  // ****************************************
  logic                       clk_i              = 1'b0;
  logic                       rst_n_i            = 1'b0;
  logic                       rxd_i;
  logic                       sample_tick_i      = 1'b0;
  logic                       double_speed_sel_i = 1'b0;
  logic [3:0]                 char_len_i         = 4'h8;
  logic                       rx_ready_i         = 1'b0;
  logic                       rx_valid_o;
  logic [ucr_pkg::DATA_W-1:0] rx_data_o;
  logic                       frame_error_flag_o;
  logic                       overrun_o;
  logic                       busy_o;
  logic [1:0]                 tdiv_ff            = 2'h0;
  logic [15:0]                seed               = 16'h0057;
  logic [15:0]                rdy_seed           = 16'h0057;
  logic                       ready_en           = 1'b1;
  int                         err_count          = 0;
  int                         checks_done        = 0;
  int                         ovr_seen           = 0;
  int                         busy_seen          = 0;
  logic [10:0]                exp_q[$];
  logic [9:0]                 msk_q[$];
  logic [10:0]                got_q[$];

  ucr_rx_top dut_u (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .rxd_i              (rxd_i),
    .sample_tick_i      (sample_tick_i),
    .double_speed_sel_i (double_speed_sel_i),
    .char_len_i         (char_len_i),
    .rx_valid_o         (rx_valid_o),
    .rx_ready_i         (rx_ready_i),
    .rx_data_o          (rx_data_o),
    .frame_error_flag_o (frame_error_flag_o),
    .overrun_o          (overrun_o),
    .busy_o             (busy_o)
  );

  ucr_tx_model tx_u (
    .clk_i  (clk_i),
    .line_o (rxd_i)
  );

  // ****************************************
  // clock, tick, consumer, monitor
  // ****************************************
  always #10 clk_i = ~clk_i;

  // exact divide keeps the receiver's own rate error at zero
  always @(posedge clk_i) begin
    tdiv_ff       <= tdiv_ff + 2'h1;
    sample_tick_i <= (tdiv_ff == 2'h3);
  end

  // consumer stalls at random
  always @(posedge clk_i) begin
    rdy_seed   <= lfsr(rdy_seed);
    rx_ready_i <= ready_en & rdy_seed[0];
  end

  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) got_q.push_back({frame_error_flag_o, rx_data_o});
    if (overrun_o === 1'b1) ovr_seen++;
    if (busy_o === 1'b1) busy_seen++;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [15:0] rnd();
    seed = lfsr(seed);
    return seed;
  endfunction : rnd

  function automatic logic [9:0] len_mask(input logic [3:0] len);
    len_mask = 10'h3ff >> (4'hA - len);
  endfunction : len_mask

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // bad stop gives frame error on that word only
  task automatic frame(input logic dbl, input logic [3:0] len, input logic [9:0] d, input logic stp,
                       input int bclk, input int stop_clks);
    @(posedge clk_i);
    double_speed_sel_i <= dbl;
    char_len_i         <= len;
    exp_q.push_back({~stp, d & len_mask(len)});
    msk_q.push_back(len_mask(len));
    tx_u.send(d, int'(len), bclk, stp, stop_clks);
  endtask : frame

  task automatic drain();
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      $display("[ERR] %0t drain timeout", $time);
      finish_test();
    end
  endtask : drain

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] r;
    logic        dbl;
    int          bclk;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({9'h000, busy_o, rx_valid_o}, 11'h000);
    repeat (64) @(posedge clk_i);
    tx_u.glitch(20);
    repeat (64) @(posedge clk_i);
    frame(1'b0, 4'h8, 10'h0a5, 1'b1, 64, 64);
    repeat (64) @(posedge clk_i);
    frame(1'b0, 4'h8, 10'h03c, 1'b1, 64, 48);
    frame(1'b0, 4'h8, 10'h0c3, 1'b1, 64, 64);
    repeat (64) @(posedge clk_i);
    // out-of-range length runs as ten bits
    char_len_i <= 4'hF;
    exp_q.push_back({1'b0, 10'h2b6});
    msk_q.push_back(10'h3ff);
    tx_u.send(10'h2b6, 10, 64, 1'b1, 64);
    repeat (64) @(posedge clk_i);
    double_speed_sel_i <= 1'b1;
    tx_u.glitch(8);
    repeat (64) @(posedge clk_i);
    frame(1'b1, 4'h8, 10'h05a, 1'b1, 32, 24);
    frame(1'b1, 4'h8, 10'h1a5, 1'b1, 32, 32);
    repeat (64) @(posedge clk_i);
    // every length in both modes, rate jitter forces realignment each frame
    for (int i = 0; i < 24; i++) begin
      r    = rnd();
      dbl  = ((i / 6) % 2) == 1;
      bclk = dbl ? 31 + int'(r[15:12] % 3) : 62 + int'(r[15:12] % 5);
      frame(dbl, 4'h5 + 4'(i % 6), r[9:0], r[11:10] != 2'b00, bclk, bclk * (1 + i % 2));
      repeat (bclk) @(posedge clk_i);
    end
    drain();
    // fill fifo and holding word, tenth frame is dropped
    ready_en <= 1'b0;
    // idle gap after each frame so a low stop is followed by a ticked high sample
    for (int i = 0; i < 10; i++) begin
      frame(1'b1, 4'h5, 10'(i), i != 3, 32, 32);
      repeat (8) @(posedge clk_i);
    end
    void'(exp_q.pop_back());
    void'(msk_q.pop_back());
    repeat (64) @(posedge clk_i);
    ready_en <= 1'b1;
    drain();
    repeat (64) @(posedge clk_i);
    check(11'(ovr_seen), 11'h001);
    check({10'h000, busy_seen != 0}, 11'h001);
    check(11'(got_q.size()), 11'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      check({got_q[i][10], got_q[i][9:0] & msk_q[i]}, exp_q[i]);
    end
    finish_test();
  end
endmodule : uart_rx_clock_data_recovery_tb
